/* File: hdl/ssd_pkg.sv */
// shared constants and types for the sense select, sync and direct input block
package ssd_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WDOG_TIMEOUT_MS = 310;
  localparam int unsigned IN_LOW_MS = 250;
  localparam int unsigned SETTLE_NS = 2000;
  localparam int unsigned WDOG_CYC_DEF = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned IN_LOW_CYC_DEF = IN_LOW_MS * (CLK_HZ / 1000);
  // least time, rounded up to whole cycles
  localparam int unsigned SETTLE_CYC_DEF = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ==========================================================================
  // sense path
  localparam int unsigned SENSE_W = 10;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [1:0] {
    SSD_SEL_OFF  = 2'h0,
    SSD_SEL_CH0  = 2'h1,
    SSD_SEL_CH1  = 2'h2,
    SSD_SEL_TEMP = 2'h3
  } ssd_sel_t;

  typedef enum logic [1:0] {
    SSD_MODE_NORMAL   = 2'h0,
    SSD_MODE_SLEEP    = 2'h1,
    SSD_MODE_FAILSAFE = 2'h2
  } ssd_mode_t;

  typedef struct packed {
    logic oe;
    logic [SENSE_W-1:0] value;
  } ssd_sense_t;

  localparam ssd_sense_t SENSE_RST = '{oe: 1'b0, value: '0};

endpackage : ssd_pkg

/* File: hdl/ssd_pin_sync.sv */
// three-stage synchroniser for an asynchronous pin with agreement filter
module ssd_pin_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================================
  // stage chain: first stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change only counts once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end

endmodule : ssd_pin_sync

/* File: hdl/ssd_sense_ctrl.sv */
// sense output selection, sense-ready pin and direct channel inputs
// Behaviour
// - The sense output carries channel 0 current, channel 1 current or die temperature as the two select bits choose.
// - With both select bits clear the sense output is not driven, so several devices can share one pull-down.
// - In hold mode the sense output keeps the current captured just before the monitored channel switched off.
// - The sense output is disabled while an overcurrent blanking window is active on the monitored channel.
// - Sensing is unavailable in fail-safe mode and in normal mode without the logic supply.
// - The ready pin is pulled low once the sense output has settled and may be sampled.
// - The ready pin is released, giving a rising edge, when the monitored channel turns off.
// - The ready pin is open drain: it is pulled low or released, never driven high.
// - Under direct control each channel is off while its direct input is low and on while it is high.
// - In sleep mode a low-to-high transition on either direct input wakes the device.
// - In fail-safe mode each channel follows its direct input level, so inputs held high turn it on.
// - Unless the watchdog is disabled, no valid serial contact for the timeout enters fail-safe mode.
// - Under direct control an input held low for the hold-low time requests a delatch; both inputs held low request sleep.
module ssd_sense_ctrl
  import ssd_pkg::*;
#(
  parameter int unsigned WDOG_CYC = WDOG_CYC_DEF,
  parameter int unsigned IN_LOW_CYC = IN_LOW_CYC_DEF,
  parameter int unsigned SETTLE_CYC = SETTLE_CYC_DEF
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // configuration
  input wire logic sense_sel_lo_i,
  input wire logic sense_sel_hi_i,
  input wire logic hold_mode_i,
  input wire logic watchdog_off_bit_i,
  input wire logic direct_mode_i,
  input wire logic logic_supply_ok_i,
  // serial side events and channel commands
  input wire logic spi_contact_i,
  input wire logic [1:0] spi_ch_on_i,
  // power stage status and analog codes
  input wire logic [1:0] ocp_blank_i,
  input wire logic [SENSE_W-1:0] ch0_current_i,
  input wire logic [SENSE_W-1:0] ch1_current_i,
  input wire logic [SENSE_W-1:0] temp_i,
  // direct input pins
  input wire logic direct_in_a_i,
  input wire logic direct_in_b_i,
  // sense output and open-drain ready pin
  output ssd_sense_t sense_out_o,
  input wire logic sense_ready_i,
  output logic sense_ready_o,
  output logic sense_ready_oe_o,
  // channel drive and status
  output logic [1:0] switch_outputs_o,
  output ssd_mode_t mode_o,
  output logic [1:0] delatch_req_o,
  output logic sleep_req_o
);

  // ==========================================================================
  // decode helpers
  function automatic logic sel_is_chan(input ssd_sel_t s);
    return (s == SSD_SEL_CH0) || (s == SSD_SEL_CH1);
  endfunction : sel_is_chan

  function automatic logic sel_idx(input ssd_sel_t s);
    return (s == SSD_SEL_CH1);
  endfunction : sel_idx

  ssd_sel_t sel;
  logic [1:0] din_s;
  logic [1:0] din_prev_q;
  logic [1:0] din_rise;
  logic [CNT_W-1:0] wdog_q;
  logic [CNT_W-1:0] low_cnt_q [2];
  logic [1:0] low_done;
  logic [1:0] sw_d;
  logic [CNT_W-1:0] settle_q;
  logic [SENSE_W-1:0] held_q [2];
  logic avail;
  logic mon_on_d;
  logic mon_blank;
  logic wdog_fire;
  ssd_sense_t sense_d;
  ssd_mode_t mode_q;

  assign sel = ssd_sel_t'({sense_sel_hi_i, sense_sel_lo_i});
  assign mode_o = mode_q;

  // ==========================================================================
  // direct input pins
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_din
      ssd_pin_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(gi == 0 ? direct_in_a_i : direct_in_b_i),
        .level_o(din_s[gi])
      );

      // hold-low timer saturates so one long low gives one request
      always_ff @(posedge clk_sys_i) begin
        if (rst_i || din_s[gi] || !direct_mode_i) begin
          low_cnt_q[gi] <= '0;
        end else if (!low_done[gi]) begin
          low_cnt_q[gi] <= low_cnt_q[gi] + 1'b1;
        end
      end
      assign low_done[gi] = (low_cnt_q[gi] == CNT_W'(IN_LOW_CYC));
    end
  endgenerate

  // edge detect on the filtered level, never on a raw stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      din_prev_q <= 2'h0;
    end else begin
      din_prev_q <= din_s;
    end
  end
  assign din_rise = din_s & ~din_prev_q;

  // one-cycle requests when the hold-low time is reached
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      delatch_req_o <= 2'h0;
      sleep_req_o <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        delatch_req_o[i] <= (low_cnt_q[i] == CNT_W'(IN_LOW_CYC - 1)) && !din_s[i] && direct_mode_i;
      end
      sleep_req_o <= (mode_q == SSD_MODE_NORMAL) && !wdog_fire && direct_mode_i && (&low_done);
    end
  end

  // ==========================================================================
  // watchdog: serial contact restarts it, disable bit freezes it at zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || spi_contact_i || watchdog_off_bit_i || mode_q != SSD_MODE_NORMAL) begin
      wdog_q <= '0;
    end else if (wdog_q != CNT_W'(WDOG_CYC)) begin
      wdog_q <= wdog_q + 1'b1;
    end
  end
  assign wdog_fire = !watchdog_off_bit_i && !spi_contact_i && (wdog_q == CNT_W'(WDOG_CYC - 1));

  // mode machine
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_q <= SSD_MODE_NORMAL;
    end else begin
      unique case (mode_q)
        SSD_MODE_NORMAL: begin
          if (wdog_fire) begin
            mode_q <= SSD_MODE_FAILSAFE;
          end else if (direct_mode_i && (&low_done)) begin
            mode_q <= SSD_MODE_SLEEP;
          end
        end
        SSD_MODE_SLEEP: begin
          if (|din_rise) begin
            mode_q <= SSD_MODE_NORMAL;
          end
        end
        SSD_MODE_FAILSAFE: begin
          if (spi_contact_i) begin
            mode_q <= SSD_MODE_NORMAL;
          end
        end
        default: begin
          mode_q <= SSD_MODE_NORMAL;
        end
      endcase
    end
  end

  // ==========================================================================
  // channel drive
  always_comb begin
    unique case (mode_q)
      SSD_MODE_FAILSAFE: sw_d = din_s;
      SSD_MODE_NORMAL: sw_d = direct_mode_i ? din_s : spi_ch_on_i;
      default: sw_d = 2'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      switch_outputs_o <= 2'h0;
    end else begin
      switch_outputs_o <= sw_d;
    end
  end

  // ==========================================================================
  // sense output
  // hold registers track the live current while a channel conducts
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      held_q[0] <= '0;
      held_q[1] <= '0;
    end else begin
      if (switch_outputs_o[0]) held_q[0] <= ch0_current_i;
      if (switch_outputs_o[1]) held_q[1] <= ch1_current_i;
    end
  end

  assign mon_blank = sel_is_chan(sel) && ocp_blank_i[sel_idx(sel)];
  assign avail = (mode_q == SSD_MODE_NORMAL) && logic_supply_ok_i && (sel != SSD_SEL_OFF) && !mon_blank;

  always_comb begin
    sense_d = SENSE_RST;
    sense_d.oe = avail;
    unique case (sel)
      SSD_SEL_CH0: sense_d.value = (hold_mode_i && !switch_outputs_o[0]) ? held_q[0] : ch0_current_i;
      SSD_SEL_CH1: sense_d.value = (hold_mode_i && !switch_outputs_o[1]) ? held_q[1] : ch1_current_i;
      SSD_SEL_TEMP: sense_d.value = temp_i;
      SSD_SEL_OFF: sense_d.value = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sense_out_o <= SENSE_RST;
    end else begin
      sense_out_o <= sense_d;
    end
  end

  // ==========================================================================
  // ready pin: settle timer restarts whenever the reading is not usable
  // temperature has no switching edge, so it settles from selection
  assign mon_on_d = sel_is_chan(sel) ? sw_d[sel_idx(sel)] : 1'b1;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !avail || !mon_on_d) begin
      settle_q <= '0;
    end else if (settle_q != CNT_W'(SETTLE_CYC)) begin
      settle_q <= settle_q + 1'b1;
    end
  end

  // released in the same edge as the channel drive falls
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sense_ready_oe_o <= 1'b0;
    end else begin
      sense_ready_oe_o <= avail && mon_on_d && (settle_q >= CNT_W'(SETTLE_CYC - 1));
    end
  end
  assign sense_ready_o = 1'b0;

  // ==========================================================================
  // checks
  chk_sense_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (avail && sel == SSD_SEL_TEMP) |=> (sense_out_o.oe && sense_out_o.value == $past(temp_i)))
    else $error("temperature not routed to sense output");
  chk_sense_code: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (avail && sel == SSD_SEL_CH1 && !hold_mode_i) |=> (sense_out_o.value == $past(ch1_current_i)))
    else $error("select code 10 did not route channel 1");
  chk_sense_tristate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (sel == SSD_SEL_OFF) |=> !sense_out_o.oe)
    else $error("sense output driven with select cleared");
  chk_hold_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ($fell(switch_outputs_o[0]) && hold_mode_i && sel == SSD_SEL_CH0 && avail) |=>
      (sense_out_o.value == $past(ch0_current_i, 2)))
    else $error("held value differs from last current before turn-off");
  chk_blank_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (sel == SSD_SEL_CH0 && ocp_blank_i[0]) |=> (!sense_out_o.oe && !sense_ready_oe_o))
    else $error("sense active during blanking window");
  chk_failsafe_nosense: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_q == SSD_MODE_FAILSAFE || !logic_supply_ok_i) |=> !sense_out_o.oe)
    else $error("sense active in fail-safe or without supply");
  chk_ready_pull: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(sense_ready_oe_o) |-> (sense_out_o.oe && settle_q >= CNT_W'(SETTLE_CYC - 1)))
    else $error("ready pulled low before settling");
  chk_ready_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ($fell(switch_outputs_o[0]) && sel == SSD_SEL_CH0 && $stable(sel)) |-> !sense_ready_oe_o)
    else $error("ready not released at turn-off");
  chk_ready_od: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sense_ready_oe_o |-> !sense_ready_o)
    else $error("ready pin driven high");
  chk_direct_follow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_q == SSD_MODE_NORMAL && direct_mode_i) |=> (switch_outputs_o == $past(din_s)))
    else $error("channel does not follow direct input");
  chk_sleep_wake: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_q == SSD_MODE_SLEEP && |din_rise) |=> (mode_q == SSD_MODE_NORMAL))
    else $error("no wake on direct input rising edge");
  chk_failsafe_follow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_q == SSD_MODE_FAILSAFE) |=> (switch_outputs_o == $past(din_s)))
    else $error("fail-safe channel does not follow input");
  chk_wdog_entry: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mode_q == SSD_MODE_NORMAL && !watchdog_off_bit_i && !spi_contact_i && wdog_q == CNT_W'(WDOG_CYC - 1))
      |=> (mode_q == SSD_MODE_FAILSAFE))
    else $error("watchdog timeout did not enter fail-safe");
  chk_low_request: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(delatch_req_o[0]) |-> ($past(din_s[0]) == 1'b0 && low_cnt_q[0] == CNT_W'(IN_LOW_CYC)))
    else $error("delatch request without hold-low time");

endmodule : ssd_sense_ctrl

/* File: sim/ssd_mcu_model.sv */
// controller-side model: direct pin drivers, ready pull-up, sense pull-down and sampler
module ssd_mcu_model
  import ssd_pkg::*;
#(
  parameter int unsigned READ_DLY = 2
) (
  // clock
  input wire logic clk_sys_i,
  // pin levels asked for by the bench
  input wire logic want_a_i,
  input wire logic want_b_i,
  // device pins
  input wire ssd_sense_t sense_i,
  input wire logic ready_drv_i,
  input wire logic ready_oe_i,
  output logic ready_pin_o,
  output logic direct_in_a_o,
  output logic direct_in_b_o,
  // value taken inside the read window
  output logic [SENSE_W-1:0] sample_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] low_q = 8'h00;
  logic [SENSE_W-1:0] sample_q = '0;
  logic [SENSE_W-1:0] pin_v;

  // ==========================================================================
  // pins
  // a released ready line rises through the pull-up, so a stale low never lingers
  assign ready_pin_o = ready_oe_i ? ready_drv_i : 1'b1;
  // a tri-stated sense pin reads the pull-down level, not the last value
  assign pin_v = sense_i.oe ? sense_i.value : '0;
  // push-pull controller outputs
  assign direct_in_a_o = want_a_i;
  assign direct_in_b_o = want_b_i;

  // ==========================================================================
  // sampler
  // waits the read delay after the fall and reads only while the line is still low
  always_ff @(posedge clk_sys_i) begin
    if (ready_pin_o !== 1'b0) begin
      low_q <= 8'h00;
    end else if (low_q <= 8'(READ_DLY)) begin
      low_q <= low_q + 8'h01;
    end
    if (ready_pin_o === 1'b0 && low_q == 8'(READ_DLY)) begin
      sample_q <= pin_v;
    end
  end
  assign sample_o = sample_q;
endmodule : ssd_mcu_model

/* File: sim/ssd_sense_ctrl_bench.sv */
// self-checking bench for the sense select, sync and direct input block
module ssd_sense_ctrl_bench
  import ssd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // short counts keep the run brief
  localparam int unsigned WDOG = 50;
  localparam int unsigned INLOW = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel_lo = 1'b0, sel_hi = 1'b0, hold = 1'b0, wd_off = 1'b1, dmode = 1'b0;
  logic sup_ok = 1'b1, contact = 1'b0, want_a = 1'b0, want_b = 1'b0;
  logic [1:0] ch_cmd = 2'h0, blank = 2'h0;
  logic [SENSE_W-1:0] cur0 = 10'h123, cur1 = 10'h2B4, temp = 10'h0F7;
  ssd_sense_t sense;
  ssd_mode_t mode;
  logic rdy_drv, rdy_oe, rdy_pin, pin_a, pin_b, slp;
  logic [1:0] sw, dl;
  logic [SENSE_W-1:0] sample;
  int failures = 0;
  int cmp_count = 0;

  // ==========================================================================
  // instances
  ssd_sense_ctrl #(.WDOG_CYC(WDOG), .IN_LOW_CYC(INLOW), .SETTLE_CYC(3)) i_ssd_sense_ctrl (
    .clk_sys_i(clk), .rst_i(rst), .sense_sel_lo_i(sel_lo), .sense_sel_hi_i(sel_hi),
    .hold_mode_i(hold), .watchdog_off_bit_i(wd_off), .direct_mode_i(dmode),
    .logic_supply_ok_i(sup_ok), .spi_contact_i(contact), .spi_ch_on_i(ch_cmd),
    .ocp_blank_i(blank), .ch0_current_i(cur0), .ch1_current_i(cur1), .temp_i(temp),
    .direct_in_a_i(pin_a), .direct_in_b_i(pin_b), .sense_out_o(sense),
    .sense_ready_i(rdy_pin), .sense_ready_o(rdy_drv), .sense_ready_oe_o(rdy_oe),
    .switch_outputs_o(sw), .mode_o(mode), .delatch_req_o(dl), .sleep_req_o(slp));
  ssd_mcu_model #(.READ_DLY(2)) i_ssd_mcu_model (
    .clk_sys_i(clk), .want_a_i(want_a), .want_b_i(want_b), .sense_i(sense),
    .ready_drv_i(rdy_drv), .ready_oe_i(rdy_oe), .ready_pin_o(rdy_pin),
    .direct_in_a_o(pin_a), .direct_in_b_o(pin_b), .sample_o(sample));

  // ==========================================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // inputs move at the falling edge, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // scenarios
  // every select code, blanking of the monitored channel only, missing supply
  task automatic t_select();
    logic [SENSE_W-1:0] exp_v [4];
    exp_v = '{10'h000, 10'h123, 10'h2B4, 10'h0F7};
    ch_cmd = 2'h3;
    for (int k = 0; k < 4; k++) begin
      {sel_hi, sel_lo} = k[1:0];
      cyc(6);
      check(16'(sense.oe), 16'(k != 0));
      if (k != 0) check(16'(sense.value), 16'(exp_v[k]));
    end
    {sel_hi, sel_lo} = 2'h1;
    blank = 2'h1;
    cyc(3);
    check(16'(sense.oe), 16'h0000);
    {sel_hi, sel_lo} = 2'h2;
    cyc(3);
    check(16'(sense.oe), 16'h0001);
    blank = 2'h0;
    sup_ok = 1'b0;
    cyc(3);
    check(16'(sense.oe), 16'h0000);
    sup_ok = 1'b1;
    ch_cmd = 2'h0;
  endtask : t_select
  // ready settles after turn-in, the read window, release at turn-off, held value
  task automatic t_ready();
    int n;
    {sel_hi, sel_lo} = 2'h1;
    hold = 1'b1;
    cyc(4);
    ch_cmd = 2'h1;
    for (n = 0; n < 8 && sw[0] !== 1'b1; n++) cyc(1);
    check(16'(rdy_oe), 16'h0000);
    for (n = 0; n < 10 && rdy_oe !== 1'b1; n++) cyc(1);
    check(16'({rdy_oe, rdy_pin}), 16'h0002);
    cyc(4);
    check(16'(sample), 16'h0123);
    ch_cmd = 2'h0;
    for (n = 0; n < 8 && sw[0] !== 1'b0; n++) cyc(1);
    check(16'({rdy_oe, rdy_pin, rdy_drv}), 16'h0002);
    cur0 = 10'h0AA;
    cyc(4);
    check(16'(sense), 16'h0523);
    hold = 1'b0;
    cur0 = 10'h123;
  endtask : t_ready
  // direct control, hold-low requests, sleep and wake on a rising input
  task automatic t_direct();
    int na = 0;
    int nb = 0;
    int ns = 0;
    dmode = 1'b1;
    want_a = 1'b1;
    cyc(8);
    check(16'(sw), 16'h0001);
    want_a = 1'b0;
    want_b = 1'b1;
    cyc(8);
    check(16'(sw), 16'h0002);
    want_b = 1'b0;
    repeat (INLOW + 12) begin
      cyc(1);
      if (dl[0] === 1'b1) na++;
      if (dl[1] === 1'b1) nb++;
      if (slp === 1'b1) ns++;
    end
    check(16'(na), 16'h0001);
    check(16'(nb), 16'h0001);
    check(16'(ns), 16'h0001);
    check(16'({mode, sw}), 16'({SSD_MODE_SLEEP, 2'h0}));
    want_a = 1'b1;
    cyc(8);
    check(16'(mode), 16'(SSD_MODE_NORMAL));
    dmode = 1'b0;
    want_a = 1'b0;
    cyc(8);
  endtask : t_direct
  // watchdog expiry, fail-safe follows the pins with sensing off, contact exits
  task automatic t_wdog();
    int n;
    want_a = 1'b1;
    want_b = 1'b1;
    {sel_hi, sel_lo} = 2'h1;
    wd_off = 1'b0;
    contact = 1'b1;
    cyc(1);
    contact = 1'b0;
    cyc(WDOG - 5);
    check(16'(mode), 16'(SSD_MODE_NORMAL));
    for (n = 0; n < 12 && mode !== SSD_MODE_FAILSAFE; n++) cyc(1);
    check(16'(mode), 16'(SSD_MODE_FAILSAFE));
    cyc(8);
    check(16'(sw), 16'h0003);
    check(16'(sense.oe), 16'h0000);
    wd_off = 1'b1;
    contact = 1'b1;
    cyc(1);
    contact = 1'b0;
    cyc(2);
    check(16'(mode), 16'(SSD_MODE_NORMAL));
  endtask : t_wdog

  // ==========================================================================
  // clock, watchdog and main sequence
  initial begin
    forever #50 clk = ~clk;
  end
  // the whole run needs a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(2);
    check(16'({sw, mode, sense.oe, rdy_oe}), 16'h0000);
    t_select();
    t_ready();
    t_direct();
    t_wdog();
    close_out();
  end
endmodule : ssd_sense_ctrl_bench
